// ===== logic/swd_defs.svh
// offsets, field positions, reset values and timing counts for the synthesizer watchdog block
`ifndef SWD_DEFS_SVH
`define SWD_DEFS_SVH
`define SWD_OFF_WDCFG 12'h1C8
`define SWD_OFF_PINSTAT 12'h1C4
`define SWD_OFF_INTSTAT 12'h200
`define SWD_OFF_INTMASK 12'h204
`define SWD_OFF_CTRL 12'h208
`define SWD_IDX_WDCFG 8'h72
`define SWD_IDX_PINSTAT 8'h71
`define SWD_DLY_HI 9
`define SWD_DLY_LO 3
`define SWD_RTG_HI 2
`define SWD_RTG_LO 0
`define SWD_DLY_RESET 7'h4D
`define SWD_RTG_RESET 3'h7
`define SWD_RTG_OFF 3'h0
`define SWD_RTG_UNLIM 3'h7
`define SWD_WDCFG_RESET 16'h026F
`define SWD_DLY_SCALE_LOG2 14
`define SWD_CLK_MHZ 50
`define SWD_DEFAULT_TIMEOUT_MS 25
`define SWD_DEFAULT_TIMEOUT_CYC ((`SWD_DEFAULT_TIMEOUT_MS * `SWD_CLK_MHZ * 1000))
`define SWD_NUM_MODE_PINS 8
`endif

// ===== logic/swd_pkg.sv
// types shared by the synthesizer watchdog block
package swd_pkg;
   typedef enum logic [1:0] {
      SWD_IDLE = 2'b00,
      SWD_RUN = 2'b01,
      SWD_DONE = 2'b11
   } swd_state_e;
endpackage

// ===== logic/swd_sync2.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module swd_sync2 #(
   parameter int WIDTH = 9
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stage1 <= '0;
         dout <= '0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule // swd_sync2

// ===== logic/swd_watchdog.sv
// synthesizer watchdog timer with pin status readback behind an APB slave
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "swd_defs.svh"
module swd_watchdog #(
   parameter int NPINS = `SWD_NUM_MODE_PINS,
   parameter int SCALE_LOG2 = `SWD_DLY_SCALE_LOG2
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic recalibration_enable_pin,
   input wire logic [NPINS-1:0] pin_mode,
   output logic watchdog_fire,
   output logic irq
);
   localparam int CW = SCALE_LOG2 + 7;
   initial begin
      if (NPINS != 8 || SCALE_LOG2 < 1 || SCALE_LOG2 > 24) begin
         $error("unsupported parameter values");
      end
   end

   logic [NPINS:0] pinSync;
   swd_sync2 #(.WIDTH(NPINS + 1)) u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .din({pin_mode, recalibration_enable_pin}),
      .dout(pinSync)
   );

   logic [6:0] watchdog_delay;
   logic [2:0] watchdog_retrigger_control;
   logic [15:0] pin_status_readback;
   logic [1:0] intStat;
   logic [1:0] intMask;
   logic [2:0] fireCount;
   logic [CW-1:0] timer;
   swd_pkg::swd_state_e state;
   swd_pkg::swd_state_e next_state;

   // apb decode; single-cycle access, pready high during every access phase
   wire access = psel && penable;
   wire wrEn = access && pwrite;
   wire rdEn = access && !pwrite;
   wire hitCfg = paddr == `SWD_OFF_WDCFG;
   wire hitPin = paddr == `SWD_OFF_PINSTAT;
   wire hitStat = paddr == `SWD_OFF_INTSTAT;
   wire hitMask = paddr == `SWD_OFF_INTMASK;
   wire hitCtrl = paddr == `SWD_OFF_CTRL;
   wire mapped = hitCfg || hitPin || hitStat || hitMask || hitCtrl;
   wire cfgWr = wrEn && hitCfg;
   wire kick = wrEn && hitCtrl && pwdata[0];
   wire [15:0] cfgWord = {6'h00, watchdog_delay, watchdog_retrigger_control};
   wire [CW-1:0] timeoutCyc = {watchdog_delay, {SCALE_LOG2{1'b0}}};
   wire [CW-1:0] timeoutLast = timeoutCyc - CW'(1);
   wire disabled = watchdog_retrigger_control == `SWD_RTG_OFF;
   wire unlimited = watchdog_retrigger_control == `SWD_RTG_UNLIM;
   wire expire = state == swd_pkg::SWD_RUN && timer >= timeoutLast;
   wire exhausted = !unlimited && (fireCount + 3'h1 >= watchdog_retrigger_control);
   wire [1:0] events = {expire && exhausted, expire};
   wire [31:0] rdMux = hitCfg ? {16'h0000, cfgWord} :
                       hitPin ? {16'h0000, pin_status_readback} :
                       hitStat ? {30'h00000000, intStat} :
                       hitMask ? {30'h00000000, intMask} :
                       32'h00000000;

   // status word: upper seven bits reserved read zero
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pin_status_readback <= 16'h0000;
      end else begin
         pin_status_readback <= {7'h00, pinSync};
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         watchdog_delay <= `SWD_DLY_RESET;
         watchdog_retrigger_control <= `SWD_RTG_RESET;
      end else if (cfgWr) begin
         watchdog_delay <= pwdata[`SWD_DLY_HI:`SWD_DLY_LO];
         watchdog_retrigger_control <= pwdata[`SWD_RTG_HI:`SWD_RTG_LO];
      end
   end

   // state machine: idle until enabled, run counts, done after count exhausted
   always_comb begin
      next_state = state;
      unique case (state)
         swd_pkg::SWD_IDLE: if (!disabled) next_state = swd_pkg::SWD_RUN;
         swd_pkg::SWD_RUN: begin
            if (disabled) next_state = swd_pkg::SWD_IDLE;
            else if (expire && exhausted) next_state = swd_pkg::SWD_DONE;
         end
         swd_pkg::SWD_DONE: begin
            if (disabled || cfgWr || kick) next_state = swd_pkg::SWD_IDLE;
         end
         default: next_state = swd_pkg::SWD_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= swd_pkg::SWD_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // timer restarts on config write, kick or expiry
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         timer <= '0;
      end else if (state != swd_pkg::SWD_RUN || cfgWr || kick || expire) begin
         timer <= '0;
      end else begin
         timer <= timer + CW'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fireCount <= 3'h0;
      end else if (state == swd_pkg::SWD_IDLE || cfgWr || kick) begin
         fireCount <= 3'h0;
      end else if (expire && !unlimited) begin
         fireCount <= fireCount + 3'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         watchdog_fire <= 1'b0;
      end else begin
         watchdog_fire <= expire;
      end
   end

   // sticky status: a read clears only the bits it reported, so an event
   // landing between the setup and access edges is not lost; set wins
   wire statRead = rdEn && hitStat;
   wire [1:0] clrBits = statRead ? prdata[1:0] : 2'h0;
   wire [1:0] next_intStat = (intStat & ~clrBits) | events;
   // irq follows the mask value that takes effect at the same edge
   wire [1:0] next_intMask = (wrEn && hitMask) ? pwdata[1:0] : intMask;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         intStat <= 2'h0;
         intMask <= 2'h0;
         irq <= 1'b0;
      end else begin
         intStat <= next_intStat;
         intMask <= next_intMask;
         irq <= |(next_intStat & next_intMask);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !(paddr == `SWD_OFF_WDCFG || paddr == `SWD_OFF_PINSTAT ||
                    paddr == `SWD_OFF_INTSTAT || paddr == `SWD_OFF_INTMASK || paddr == `SWD_OFF_CTRL);
         prdata <= (psel && !penable && !pwrite) ? rdMux : 32'h00000000;
      end
   end

   a_disable_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
      disabled |=> state == swd_pkg::SWD_IDLE || $past(state) != swd_pkg::SWD_RUN)
      else $error("watchdog kept running while disabled");
   a_fire_follows: assert property (@(posedge clk_sys) disable iff (!nrst)
      expire |=> watchdog_fire)
      else $error("expiry did not pulse fire");
   a_limit_stops: assert property (@(posedge clk_sys) disable iff (!nrst)
      expire && exhausted |=> state == swd_pkg::SWD_DONE || $past(cfgWr || kick || disabled))
      else $error("watchdog did not stop after last fire");
   a_unlim_run: assert property (@(posedge clk_sys) disable iff (!nrst)
      expire && unlimited && !cfgWr |=> state == swd_pkg::SWD_RUN)
      else $error("unlimited watchdog stopped");
   a_timeout_len: assert property (@(posedge clk_sys) disable iff (!nrst)
      expire |-> timer == timeoutLast)
      else $error("timeout length wrong");
   a_cfg_reserved: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfgWord[15:10] == 6'h00 && pin_status_readback[15:9] == 7'h00)
      else $error("reserved bits not zero");
   a_pin_track: assert property (@(posedge clk_sys) disable iff (!nrst)
      ##1 pin_status_readback[8:0] == $past(pinSync))
      else $error("pin status not tracking");
   // only meaningful at the real scale; within two percent of the nominal period
   a_default_time: assert property (@(posedge clk_sys) disable iff (!nrst)
      watchdog_delay == `SWD_DLY_RESET && SCALE_LOG2 == `SWD_DLY_SCALE_LOG2 |->
      64'(timeoutCyc) * 64'd100 <= 64'(`SWD_DEFAULT_TIMEOUT_CYC) * 64'd102 &&
      64'(timeoutCyc) * 64'd100 >= 64'(`SWD_DEFAULT_TIMEOUT_CYC) * 64'd98)
      else $error("default timeout away from nominal");
   a_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst)
      ##1 irq == |(intStat & intMask))
      else $error("irq mismatch");

   // bus answer timing
   a_pready_access: assert property (@(posedge clk_sys) disable iff (!nrst)
      psel && !penable |=> pready)
      else $error("pready missing in access phase");
   a_pready_only: assert property (@(posedge clk_sys) disable iff (!nrst)
      !(psel && !penable) |=> !pready)
      else $error("pready outside access phase");
   a_slverr_unmapped: assert property (@(posedge clk_sys) disable iff (!nrst)
      psel && !penable && !mapped |=> pslverr)
      else $error("no error for unmapped address");
   a_slverr_mapped: assert property (@(posedge clk_sys) disable iff (!nrst)
      psel && !penable && mapped |=> !pslverr)
      else $error("error for mapped address");
   a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
      !(psel && !penable && !pwrite) |=> prdata == 32'h00000000)
      else $error("read data not zero outside reads");

   // configuration register
   a_cfg_write: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfgWr |=> watchdog_delay == $past(pwdata[`SWD_DLY_HI:`SWD_DLY_LO]))
      else $error("delay field not written");
   a_rtg_write: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfgWr |=> watchdog_retrigger_control == $past(pwdata[`SWD_RTG_HI:`SWD_RTG_LO]))
      else $error("retrigger field not written");
   a_cfg_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
      !cfgWr |=> $stable(watchdog_delay) && $stable(watchdog_retrigger_control))
      else $error("configuration changed without write");

   // timer and fire behaviour
   a_fire_single: assert property (@(posedge clk_sys) disable iff (!nrst)
      watchdog_fire |=> !watchdog_fire)
      else $error("fire wider than one cycle");
   a_fire_running: assert property (@(posedge clk_sys) disable iff (!nrst)
      watchdog_fire |-> $past(state) == swd_pkg::SWD_RUN)
      else $error("fire while not running");
   a_count_bound: assert property (@(posedge clk_sys) disable iff (!nrst)
      state == swd_pkg::SWD_RUN && !unlimited && !disabled |-> fireCount < watchdog_retrigger_control)
      else $error("fire count beyond limit");
   a_idle_timer: assert property (@(posedge clk_sys) disable iff (!nrst)
      state != swd_pkg::SWD_RUN |=> timer == '0)
      else $error("timer moved while not running");
   a_kick_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
      kick && state == swd_pkg::SWD_RUN |=> timer == '0)
      else $error("kick did not restart timer");

   // sticky status flags
   a_stat_set: assert property (@(posedge clk_sys) disable iff (!nrst)
      expire |=> intStat[0])
      else $error("expiry did not set status");
   a_stat_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
      intStat[0] && !statRead |=> intStat[0])
      else $error("status bit lost without read");
   a_stat_done: assert property (@(posedge clk_sys) disable iff (!nrst)
      expire && exhausted |=> intStat[1])
      else $error("exhaustion did not set status");
   c_fire: cover property (@(posedge clk_sys) disable iff (!nrst) watchdog_fire);
   c_done: cover property (@(posedge clk_sys) disable iff (!nrst) state == swd_pkg::SWD_DONE);
   c_stat_read: cover property (@(posedge clk_sys) disable iff (!nrst) statRead && intStat != 2'h0);
   c_unlim_refire: cover property (@(posedge clk_sys) disable iff (!nrst) watchdog_fire && unlimited);
   c_kick_done: cover property (@(posedge clk_sys) disable iff (!nrst) kick && state == swd_pkg::SWD_DONE);
endmodule // swd_watchdog

// ===== test/tb_synth_watchdog_and_pin_status.sv
// self-checking bench for the watchdog timer and pin status readback
`timescale 1ns/1ps
module tb_synth_watchdog_and_pin_status;
   // short scale keeps every timeout to at most 2048 cycles
   localparam int SCL = 4;
   localparam int TDEF = 77 * (1 << SCL);
   logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, recalPin, wdFire, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] pinMode;
   logic [8:0] pat [2] = '{9'h14B, 9'h0B4};
   int failCount = 0, cmpCount = 0, cyc = 0, fireCount = 0, lastFire = 0, t0, f0;

   swd_watchdog #(.NPINS(8), .SCALE_LOG2(SCL)) dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .recalibration_enable_pin(recalPin), .pin_mode(pinMode), .watchdog_fire(wdFire),
      .irq(irq));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // counts expiry pulses and remembers the cycle of the latest one
   always @(posedge clk_sys) begin
      cyc++;
      if (wdFire === 1'b1) begin
         fireCount++;
         lastFire = cyc;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         failCount++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; read data and error are taken at the edge with pready high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // registered outputs are settled by the falling edge
      @(negedge clk_sys);
      while (pready !== 1'b1) begin
         @(posedge clk_sys);
         @(negedge clk_sys);
      end
      rd = prdata;
      err = pslverr;
      @(posedge clk_sys);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task endSim;
      $display("compares %0d mismatches %0d", cmpCount, failCount);
      if (failCount == 0 && cmpCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      failCount++;
      endSim();
   end

   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      recalPin = 1'b0;
      pinMode = 8'h00;
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      apb(1'b0, 12'h1C8, 32'h0);
      chk(rd, 32'h0000026F);
      apb(1'b1, 12'h1C8, 32'h0000026F);
      t0 = cyc;
      repeat (TDEF + 60) @(posedge clk_sys);
      chk({31'h0, (lastFire - t0 - TDEF) inside {[-1:4]}}, 32'h1);
      for (int i = 0; i < 2; i++) begin
         recalPin <= pat[i][0];
         pinMode <= pat[i][8:1];
         repeat (6) @(posedge clk_sys);
         apb(1'b0, 12'h1C4, 32'h0);
         chk(rd, {23'h0, pat[i]});
      end
      apb(1'b1, 12'h1C4, 32'hFFFFFFFF);
      apb(1'b0, 12'h1C4, 32'h0);
      chk(rd, {23'h0, pat[1]});
      apb(1'b1, 12'h1C8, 32'hFFFFFFFF);
      apb(1'b0, 12'h1C8, 32'h0);
      chk(rd, 32'h000003FF);
      apb(1'b0, 12'h300, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      // no drive-current register here, so the bench never programs one
      // every retrigger code with the shortest delay
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, 12'h1C8, 32'h8 | c);
         f0 = fireCount;
         repeat (200) @(posedge clk_sys);
         if (c == 7) chk({31'h0, fireCount - f0 >= 10}, 32'h1);
         else chk(fireCount - f0, c);
      end
      apb(1'b1, 12'h1C8, 32'h8);
      // same event once enabled and once masked: the level must differ
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, 12'h204, m ? 32'h0 : 32'h3);
         apb(1'b0, 12'h200, 32'h0);
         apb(1'b1, 12'h1C8, 32'h9);
         f0 = fireCount;
         repeat (40) @(posedge clk_sys);
         chk({31'h0, irq}, m ? 32'h0 : 32'h1);
         apb(1'b0, 12'h200, 32'h0);
         chk(rd, 32'h3);
         apb(1'b0, 12'h200, 32'h0);
         chk(rd, 32'h0);
         repeat (2) @(posedge clk_sys);
         chk({31'h0, irq}, 32'h0);
         chk(fireCount - f0, 32'h1);
      end
      // a kick after exhaustion restarts the count
      f0 = fireCount;
      apb(1'b1, 12'h208, 32'h1);
      repeat (60) @(posedge clk_sys);
      chk(fireCount - f0, 32'h1);
      endSim();
   end
endmodule // tb_synth_watchdog_and_pin_status
